// ---- common/sdc_flow_if.sv ----
// interface between the control logic and the flow table
`timescale 1ns/100ps
interface sdc_flow_if;
  import sdc_pkg::*;
  logic                     removeValid;
  logic [FLOW_ID_WIDTH-1:0] removeUpId;
  logic [FLOW_ID_WIDTH-1:0] removeDnId;
  logic                     removeDone;
  logic                     removedPrimary;
  logic                     removedProvisioned;
  logic                     clearAll;
  modport ctrl (output removeValid, output removeUpId, output removeDnId,
    output clearAll, input removeDone, input removedPrimary,
    input removedProvisioned);
  // named tbl because the plain word is reserved in the language
  modport tbl (input removeValid, input removeUpId, input removeDnId,
    input clearAll, output removeDone, output removedPrimary,
    output removedProvisioned);
endinterface

// ---- common/sdc_pkg.sv ----
// package of constants and types for service deletion and channel change
package sdc_pkg;
  localparam int FLOW_ID_WIDTH = 16;
  localparam int TXN_ID_WIDTH  = 16;
  localparam int FLOW_COUNT    = 8;
  localparam int FLOW_IDX_W    = 3;
  localparam int CLK_MHZ       = 250;
  // channel-change departure limit, in milliseconds
  localparam int T13_MS        = 1000;
  localparam int T13_CYCLES    = T13_MS * CLK_MHZ * 1000;
  // departure is started this many cycles before the limit
  localparam logic [31:0] DEPART_MARGIN = 32'h00000010;
  localparam logic [31:0] COUNT_RESET   = 32'h00000000;
  localparam logic [FLOW_IDX_W-1:0] FLOW_IDX_RESET = 3'h0;
  localparam logic [FLOW_ID_WIDTH-1:0] FLOW_ID_NONE = 16'h0000;
  localparam logic [TXN_ID_WIDTH-1:0] TXN_RESET = 16'h0000;
  localparam logic [TXN_ID_WIDTH-1:0] TXN_STEP = 16'h0001;

  // initialization technique carried by the channel-change command
  typedef enum logic [2:0] {
    INIT_REINIT_MAC,
    INIT_BROADCAST_RANGE,
    INIT_UNICAST_RANGE,
    INIT_RANGE_OR_DIRECT,
    INIT_DIRECT
  } sdc_init_type;

  // kind of message to send
  typedef enum logic [2:0] {
    MSG_NONE,
    MSG_DEL_REQ,
    MSG_DEL_RSP,
    MSG_DEP_RSP,
    MSG_ARR_RSP
  } sdc_msg_type;
endpackage

// ---- core/sdc_flow_table.sv ----
// table of active service flows with their classifier, primary and provisioned state
`timescale 1ns/100ps
module sdc_flow_table
  import sdc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     addValid,
  input  wire logic [FLOW_ID_WIDTH-1:0] addId,
  input  wire logic                     addPrimary,
  input  wire logic                     addProvisioned,
  output logic [FLOW_COUNT-1:0]         flowActive,
  output logic [FLOW_COUNT-1:0]         provKept,
  sdc_flow_if.tbl                       flow
);
  logic [FLOW_ID_WIDTH-1:0] id_reg [FLOW_COUNT];
  logic [FLOW_COUNT-1:0]    valid_reg;
  logic [FLOW_COUNT-1:0]    prim_reg;
  logic [FLOW_COUNT-1:0]    prov_reg;
  logic [FLOW_COUNT-1:0]    classif_reg;
  logic [FLOW_COUNT-1:0]    hit;
  logic [FLOW_COUNT-1:0]    freeSlot;
  logic [FLOW_COUNT-1:0]    firstFree;
  logic                     done_reg;
  logic                     prim_hit_reg;
  logic                     prov_hit_reg;

  // match removal ids; id zero means no flow named
  genvar g;
  generate
    for (g = 0; g < FLOW_COUNT; g++) begin : gSlot
      assign hit[g] = valid_reg[g] && flow.removeValid &&
        ((flow.removeUpId != FLOW_ID_NONE && id_reg[g] == flow.removeUpId) ||
         (flow.removeDnId != FLOW_ID_NONE && id_reg[g] == flow.removeDnId));
      assign freeSlot[g] = !valid_reg[g];
    end
  endgenerate
  assign firstFree = freeSlot & (~freeSlot + 8'h01);

  // removal frees the slot and its classifier and primary state
  always_ff @(posedge clk) begin
    if (reset || flow.clearAll) begin
      valid_reg   <= 8'h00;
      classif_reg <= 8'h00;
      prim_reg    <= 8'h00;
    end else begin
      valid_reg   <= (valid_reg & ~hit) |
                     (addValid ? firstFree : 8'h00);
      classif_reg <= (classif_reg & ~hit) |
                     (addValid ? firstFree : 8'h00);
      prim_reg    <= (prim_reg & ~hit) |
                     (addValid && addPrimary ? firstFree : 8'h00);
    end
  end

  // provisioning record is lost on delete until next registration
  always_ff @(posedge clk) begin
    if (reset || flow.clearAll) begin
      prov_reg <= 8'h00;
    end else begin
      prov_reg <= (prov_reg & ~hit) |
                  (addValid && addProvisioned ? firstFree : 8'h00);
    end
  end

  // flow identifiers
  always_ff @(posedge clk) begin
    for (int i = 0; i < FLOW_COUNT; i++) begin
      if (addValid && firstFree[i]) begin
        id_reg[i] <= addId;
      end
    end
  end

  // one-cycle answer to each removal
  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg     <= 1'b0;
      prim_hit_reg <= 1'b0;
      prov_hit_reg <= 1'b0;
    end else begin
      done_reg     <= flow.removeValid;
      prim_hit_reg <= |(hit & prim_reg);
      prov_hit_reg <= |(hit & prov_reg);
    end
  end

  assign flow.removeDone         = done_reg;
  assign flow.removedPrimary     = prim_hit_reg;
  assign flow.removedProvisioned = prov_hit_reg;
  assign flowActive              = valid_reg;
  assign provKept                = prov_reg;

  removed_cleared_a: assert property (@(posedge clk) disable iff (reset)
    (flow.removeValid && !flow.clearAll && |hit) |=> ((valid_reg | classif_reg)
      & $past(hit)) == 8'h00) else $error("removed flow left state");
  prov_lost_a: assert property (@(posedge clk) disable iff (reset)
    (|(hit & prov_reg) && !addValid) |=> !(|(prov_reg & $past(hit))))
    else $error("provisioning kept after delete");
endmodule

// ---- core/sdc_mac_mgmt.sv ----
// modem-side service deletion and channel change control
`timescale 1ns/100ps
module sdc_mac_mgmt
  import sdc_pkg::*;
#(
  parameter int T13_LIMIT = T13_CYCLES
)
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     registered,
  input  wire logic                     addValid,
  input  wire logic [FLOW_ID_WIDTH-1:0] addId,
  input  wire logic                     addPrimary,
  input  wire logic                     addProvisioned,
  input  wire logic                     localDelValid,
  input  wire logic [FLOW_ID_WIDTH-1:0] localDelUpId,
  input  wire logic [FLOW_ID_WIDTH-1:0] localDelDnId,
  output logic                          localDelReady,
  input  wire logic                     rxDelReq,
  input  wire logic                     rxDelRsp,
  input  wire logic [TXN_ID_WIDTH-1:0]  rxTxnId,
  input  wire logic [FLOW_ID_WIDTH-1:0] rxUpId,
  input  wire logic [FLOW_ID_WIDTH-1:0] rxDnId,
  input  wire logic                     rxChgReq,
  input  wire logic                     rxChgUp,
  input  wire logic                     rxChgDn,
  input  wire logic                     rxInitPresent,
  input  wire sdc_init_type             rxInitTech,
  input  wire logic                     txReady,
  output sdc_msg_type                   txMsg,
  output logic [TXN_ID_WIDTH-1:0]       txTxnId,
  output logic [FLOW_ID_WIDTH-1:0]      txUpId,
  output logic [FLOW_ID_WIDTH-1:0]      txDnId,
  output logic                          jumpReq,
  output logic                          jumpUp,
  output logic                          jumpDn,
  input  wire logic                     syncDone,
  output logic                          reinitMac,
  output logic                          rangeOnly,
  output logic                          reregister,
  output logic                          useOldGrants,
  output logic                          useNewGrants,
  output logic                          flushBwRequests,
  output logic [FLOW_COUNT-1:0]         flowActive,
  output logic [FLOW_COUNT-1:0]         provKept
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEL_WAIT, ST_DEL_RSP, ST_DEPART, ST_JUMP, ST_ARRIVE
  } sdc_state_type;

  sdc_flow_if flow ();

  sdc_state_type            state_reg;
  logic [TXN_ID_WIDTH-1:0]  txn_reg;
  logic [TXN_ID_WIDTH-1:0]  rxTxn_reg;
  logic [FLOW_ID_WIDTH-1:0] up_reg;
  logic [FLOW_ID_WIDTH-1:0] dn_reg;
  logic                     chgUp_reg;
  logic                     chgDn_reg;
  sdc_init_type             tech_reg;
  logic [31:0]              t13_reg;
  logic                     reinit_reg;
  logic                     range_reg;
  logic                     rereg_reg;
  logic                     flush_reg;
  logic                     txSend;
  logic                     flow_remote_reg;

  sdc_flow_table uTable (
    .clk            (clk),
    .reset          (reset),
    .addValid       (addValid),
    .addId          (addId),
    .addPrimary     (addPrimary),
    .addProvisioned (addProvisioned),
    .flowActive     (flowActive),
    .provKept       (provKept),
    .flow           (flow)
  );

  // removal strobe for both local and headend deletions
  assign flow.removeValid = (state_reg == ST_IDLE && localDelValid &&
                             registered) ||
                            (state_reg == ST_IDLE && rxDelReq);
  assign flow.removeUpId = rxDelReq ? rxUpId : localDelUpId;
  assign flow.removeDnId = rxDelReq ? rxDnId : localDelDnId;
  assign flow.clearAll   = reinit_reg; // deregistration drops every flow
  // headend requests win over local ones in the same cycle
  assign localDelReady   = state_reg == ST_IDLE && registered && !rxDelReq;
  assign txSend = txMsg != MSG_NONE && txReady;

  // transaction sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (rxDelReq) begin
            state_reg <= ST_DEL_RSP;
          end else if (localDelValid && registered) begin
            state_reg <= ST_DEL_WAIT;
          end else if (rxChgReq && registered && (rxChgUp || rxChgDn)) begin
            state_reg <= ST_DEPART;
          end
        end
        ST_DEL_WAIT: if (txSend) state_reg <= ST_DEL_RSP;
        ST_DEL_RSP: begin
          if (txMsg == MSG_DEL_RSP ? txSend : rxDelRsp) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DEPART: begin
          // leave once depart is sent, at the latest near T13
          if (txSend || t13_reg >= T13_LIMIT - DEPART_MARGIN) begin
            state_reg <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          if (syncDone) begin
            state_reg <= reinit_next() ? ST_IDLE : ST_ARRIVE;
          end
        end
        ST_ARRIVE: if (txSend) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  function automatic logic reinit_next();
    reinit_next = tech_reg == INIT_REINIT_MAC;
  endfunction

  // latch command contents; a repeated change request restarts T13
  always_ff @(posedge clk) begin
    if (reset) begin
      t13_reg   <= COUNT_RESET;
      chgUp_reg <= 1'b0;
      chgDn_reg <= 1'b0;
      tech_reg  <= INIT_REINIT_MAC;
      rxTxn_reg <= TXN_RESET;
      up_reg    <= FLOW_ID_NONE;
      dn_reg    <= FLOW_ID_NONE;
    end else begin
      if (rxChgReq && (state_reg == ST_IDLE || state_reg == ST_DEPART)) begin
        t13_reg   <= COUNT_RESET;
        chgUp_reg <= rxChgUp;
        chgDn_reg <= rxChgDn;
        tech_reg  <= rxInitPresent ? rxInitTech : INIT_REINIT_MAC;
        rxTxn_reg <= rxTxnId;
      end else if (t13_reg < 32'(T13_LIMIT)) begin
        t13_reg <= t13_reg + 32'h00000001;
      end
      if (state_reg == ST_IDLE && rxDelReq) begin
        rxTxn_reg <= rxTxnId;
        up_reg    <= rxUpId;
        dn_reg    <= rxDnId;
      end else if (state_reg == ST_IDLE && localDelValid && registered) begin
        up_reg <= localDelUpId;
        dn_reg <= localDelDnId;
      end
    end
  end

  // local transaction numbering
  always_ff @(posedge clk) begin
    if (reset) begin
      txn_reg <= TXN_RESET;
    end else if (state_reg == ST_DEL_WAIT && txSend) begin
      txn_reg <= txn_reg + TXN_STEP;
    end
  end

  // outgoing message selection
  always_comb begin
    txMsg   = MSG_NONE;
    txTxnId = rxTxn_reg;
    txUpId  = up_reg;
    txDnId  = dn_reg;
    case (state_reg)
      ST_DEL_WAIT: begin
        txMsg   = MSG_DEL_REQ;
        txTxnId = txn_reg;
      end
      ST_DEL_RSP: begin
        // a headend transaction answers; a local one only waits
        if (flow_remote_reg) txMsg = MSG_DEL_RSP;
      end
      ST_DEPART: txMsg = MSG_DEP_RSP;
      ST_ARRIVE: txMsg = MSG_ARR_RSP;
      default: txMsg = MSG_NONE;
    endcase
  end

  // remembers whether the deletion in progress came from the headend
  always_ff @(posedge clk) begin
    if (reset) begin
      flow_remote_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      flow_remote_reg <= rxDelReq;
    end
  end

  // technique outcome and deregistration effects
  always_ff @(posedge clk) begin
    if (reset) begin
      reinit_reg <= 1'b0;
      range_reg  <= 1'b0;
      rereg_reg  <= 1'b0;
      flush_reg  <= 1'b0;
    end else begin
      reinit_reg <= state_reg == ST_JUMP && syncDone &&
                    tech_reg == INIT_REINIT_MAC;
      range_reg  <= state_reg == ST_JUMP && syncDone &&
                    tech_reg != INIT_REINIT_MAC &&
                    tech_reg != INIT_DIRECT;
      // only primary loss re-registers, provisioned loss does not
      rereg_reg  <= flow.removeDone && flow.removedPrimary;
      flush_reg  <= state_reg == ST_JUMP && syncDone;
    end
  end

  assign reinitMac       = reinit_reg;
  assign rangeOnly       = range_reg;
  assign reregister      = rereg_reg;
  assign flushBwRequests = flush_reg;
  assign jumpReq         = state_reg == ST_JUMP;
  assign jumpUp          = chgUp_reg;
  assign jumpDn          = chgDn_reg;
  // old grants stay usable up to the jump, new ones only while in the arrive state
  assign useOldGrants    = state_reg != ST_JUMP &&
                           state_reg != ST_ARRIVE;
  assign useNewGrants    = state_reg == ST_ARRIVE;

  depart_in_time_a: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_DEPART |-> t13_reg < 32'(T13_LIMIT))
    else $error("departure not before T13");
  no_arrive_reinit_a: assert property (@(posedge clk) disable iff (reset)
    reinitMac |-> txMsg != MSG_ARR_RSP)
    else $error("arrive sent after reinit");
  reinit_default_a: assert property (@(posedge clk) disable iff (reset)
    (rxChgReq && state_reg == ST_IDLE && registered && !rxDelReq &&
     !localDelValid && !rxInitPresent && (rxChgUp || rxChgDn)) |=>
    tech_reg == INIT_REINIT_MAC)
    else $error("absent technique not reinit");
  primary_rereg_a: assert property (@(posedge clk) disable iff (reset)
    (flow.removeDone && flow.removedPrimary) |=> reregister)
    else $error("primary loss without reregister");
  prov_no_rereg_a: assert property (@(posedge clk) disable iff (reset)
    (flow.removeDone && !flow.removedPrimary) |=> !reregister)
    else $error("reregister without primary loss");
  flush_on_sync_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_JUMP && syncDone) |=> flushBwRequests)
    else $error("bandwidth requests not voided");
  timer_restart_a: assert property (@(posedge clk) disable iff (reset)
    (rxChgReq && state_reg == ST_DEPART) |=> t13_reg == COUNT_RESET)
    else $error("T13 not restarted");
  del_rsp_sent_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_IDLE && rxDelReq) |=> txMsg == MSG_DEL_RSP)
    else $error("no delete response");
  both_dirs_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_IDLE && rxChgReq && registered && !rxDelReq &&
     !localDelValid && rxChgUp && rxChgDn) |=> (jumpUp && jumpDn))
    else $error("both-channel change lost");
endmodule

// ---- test/sdc_headend_model.sv ----
// behavioural headend: takes modem messages, issues requests, fakes sync
`timescale 1ns/100ps
module sdc_headend_model
  import sdc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic [7:0]               rdyDelay,
  input  wire logic                     cmdDel,
  input  wire logic                     cmdChg,
  input  wire logic [FLOW_ID_WIDTH-1:0] cmdUpId,
  input  wire logic [FLOW_ID_WIDTH-1:0] cmdDnId,
  input  wire logic                     cmdChgUp,
  input  wire logic                     cmdChgDn,
  input  wire logic                     cmdInitPresent,
  input  wire sdc_init_type             cmdInitTech,
  input  wire sdc_msg_type              txMsg,
  input  wire logic [TXN_ID_WIDTH-1:0]  txTxnId,
  input  wire logic [FLOW_ID_WIDTH-1:0] txUpId,
  input  wire logic [FLOW_ID_WIDTH-1:0] txDnId,
  input  wire logic                     jumpReq,
  output logic                          txReady = 1'b0,
  output logic                          rxDelReq = 1'b0,
  output logic                          rxDelRsp = 1'b0,
  output logic                          rxChgReq = 1'b0,
  output logic [TXN_ID_WIDTH-1:0]       rxTxnId = 16'h0000,
  output logic [FLOW_ID_WIDTH-1:0]      rxUpId = 16'h0000,
  output logic [FLOW_ID_WIDTH-1:0]      rxDnId = 16'h0000,
  output logic                          rxChgUp = 1'b0,
  output logic                          rxChgDn = 1'b0,
  output logic                          rxInitPresent = 1'b0,
  output sdc_init_type                  rxInitTech = INIT_DIRECT,
  output logic                          syncDone = 1'b0,
  output sdc_msg_type                   sentMsg = MSG_NONE,
  output logic [FLOW_ID_WIDTH-1:0]      sentUp = 16'h0000,
  output logic [FLOW_ID_WIDTH-1:0]      sentDn = 16'h0000,
  output int                            sentCount = 0
);
  logic                    pendDel = 1'b0;
  logic                    pendChg = 1'b0;
  logic [7:0]              waitCnt = 8'h00;
  logic [7:0]              jumpCnt = 8'h00;
  logic [1:0]              rspCnt = 2'h0;
  logic [TXN_ID_WIDTH-1:0] rspTxn = 16'h0000;
  logic [TXN_ID_WIDTH-1:0] txnCnt = 16'h0100;
  // sim stand-in for the two to thirty-five second hold
  localparam int T15_SIM = 400;
  int                      t15Cnt = 0;
  logic [7:0]              upChan = 8'h01;

  // new-channel hold restarts on each change request sent; nothing
  // reads the count, so a late arrival is not aborted
  always @(posedge clk) begin
    if (pendChg) begin
      t15Cnt <= T15_SIM;
      upChan <= upChan + 8'h01;
    end else if (t15Cnt > 0) begin
      t15Cnt <= t15Cnt - 1;
    end
  end

  // latch bench commands and log every message the modem hands over
  always @(posedge clk) begin
    pendDel <= cmdDel;
    pendChg <= cmdChg;
    rspCnt <= (rspCnt != 2'h0) ? rspCnt - 2'h1 : 2'h0;
    if (txReady && txMsg != MSG_NONE) begin
      sentMsg <= txMsg;
      sentUp <= txUpId;
      sentDn <= txDnId;
      sentCount <= sentCount + 1;
      if (txMsg == MSG_DEL_REQ) begin
        rspCnt <= 2'h3;
        rspTxn <= txTxnId;
      end
    end
  end

  // idle qualifiers flip each cycle so a stale value can never match
  always @(negedge clk) begin
    rxDelReq <= pendDel;
    rxChgReq <= pendChg;
    rxDelRsp <= (rspCnt == 2'h1);
    if (pendDel) begin
      rxUpId <= cmdUpId;
      rxDnId <= cmdDnId;
      rxTxnId <= txnCnt;
      txnCnt <= txnCnt + 16'h0001;
    end else if (rspCnt == 2'h1) begin
      rxUpId <= sentUp;
      rxDnId <= sentDn;
      rxTxnId <= rspTxn;
    end else begin
      rxUpId <= ~rxUpId;
      rxDnId <= ~rxDnId;
      rxTxnId <= ~rxTxnId;
    end
    rxChgUp <= pendChg ? cmdChgUp : ~rxChgUp;
    rxChgDn <= pendChg ? cmdChgDn : ~rxChgDn;
    rxInitPresent <= pendChg ? cmdInitPresent : ~rxInitPresent;
    rxInitTech <= pendChg ? cmdInitTech : sdc_init_type'(~rxInitTech);
    // transmit slot after rdyDelay cycles; 8'hff never grants, so the
    // old channel is held while the modem keeps waiting
    if (txMsg != MSG_NONE && !txReady) begin
      waitCnt <= waitCnt + 8'h01;
      txReady <= (waitCnt + 8'h01 >= rdyDelay) && (rdyDelay != 8'hff);
    end else begin
      waitCnt <= 8'h00;
      txReady <= (rdyDelay == 8'h00);
    end
    // new channel found a few cycles into the jump
    jumpCnt <= jumpReq ? jumpCnt + 8'h01 : 8'h00;
    syncDone <= jumpReq && (jumpCnt == 8'h04);
  end
endmodule

// ---- test/test_service_deletion_channel_change.sv ----
// self-checking bench for service deletion and channel change control
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module test_service_deletion_channel_change;
  import sdc_pkg::*;
  localparam int T13_SIM = 200;
  logic clk, reset = 1'b1, registered = 1'b0, addValid = 1'b0;
  logic addPrimary = 1'b0, addProvisioned = 1'b0, localDelValid = 1'b0;
  logic cmdDel = 1'b0, cmdChg = 1'b0, cmdChgUp = 1'b0, cmdChgDn = 1'b0;
  logic cmdInitPresent = 1'b0;
  logic [FLOW_ID_WIDTH-1:0] addId = 16'h0000, cmdUpId = 16'h0000;
  logic [FLOW_ID_WIDTH-1:0] localDelUpId = 16'h0000, localDelDnId = 16'h0000;
  logic [FLOW_ID_WIDTH-1:0] cmdDnId = 16'h0000;
  logic [7:0] rdyDelay = 8'h00;
  sdc_init_type cmdInitTech = INIT_DIRECT;
  logic localDelReady, txReady, rxDelReq, rxDelRsp, rxChgReq, rxChgUp;
  logic rxChgDn, rxInitPresent, jumpReq, jumpUp, jumpDn, syncDone;
  logic reinitMac, rangeOnly, reregister, useOldGrants, useNewGrants;
  logic flushBwRequests;
  logic [TXN_ID_WIDTH-1:0] rxTxnId, txTxnId;
  logic [FLOW_ID_WIDTH-1:0] rxUpId, rxDnId, txUpId, txDnId, sentUp, sentDn;
  logic [FLOW_COUNT-1:0] flowActive, provKept;
  sdc_init_type rxInitTech;
  sdc_msg_type txMsg, sentMsg;
  int sentCount, failures = 0, compares = 0;
  int nRereg = 0, nReinit = 0, nRange = 0, nFlush = 0;

  sdc_mac_mgmt #(.T13_LIMIT(T13_SIM)) i_dut (
    .clk, .reset, .registered, .addValid, .addId, .addPrimary,
    .addProvisioned, .localDelValid, .localDelUpId, .localDelDnId,
    .localDelReady, .rxDelReq, .rxDelRsp, .rxTxnId, .rxUpId, .rxDnId,
    .rxChgReq, .rxChgUp, .rxChgDn, .rxInitPresent, .rxInitTech, .txReady,
    .txMsg, .txTxnId, .txUpId, .txDnId, .jumpReq, .jumpUp, .jumpDn,
    .syncDone, .reinitMac, .rangeOnly, .reregister, .useOldGrants,
    .useNewGrants, .flushBwRequests, .flowActive, .provKept
  );

  sdc_headend_model i_headend (
    .clk, .rdyDelay, .cmdDel, .cmdChg, .cmdUpId, .cmdDnId, .cmdChgUp,
    .cmdChgDn, .cmdInitPresent, .cmdInitTech, .txMsg, .txTxnId, .txUpId,
    .txDnId, .jumpReq, .txReady, .rxDelReq, .rxDelRsp, .rxChgReq, .rxTxnId,
    .rxUpId, .rxDnId, .rxChgUp, .rxChgDn, .rxInitPresent, .rxInitTech,
    .syncDone, .sentMsg, .sentUp, .sentDn, .sentCount
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulses are counted so scenarios compare before and after
  always @(posedge clk) begin
    nRereg <= nRereg + (reregister ? 1 : 0);
    nReinit <= nReinit + (reinitMac ? 1 : 0);
    nRange <= nRange + (rangeOnly ? 1 : 0);
    nFlush <= nFlush + (flushBwRequests ? 1 : 0);
  end

  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait until the headend has logged n messages
  task automatic wait_sent(input int n);
    int k;
    k = 0;
    while (sentCount < n && k < 600) begin
      @(negedge clk);
      k++;
    end
    `CHK(sentCount, n)
  endtask

  task automatic wait_jump(input logic lvl, output int k);
    k = 0;
    while (jumpReq !== lvl && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic chg(input logic up, dn, pres, input sdc_init_type tech);
    @(negedge clk);
    cmdChg = 1'b1;
    cmdChgUp = up;
    cmdChgDn = dn;
    cmdInitPresent = pres;
    cmdInitTech = tech;
    @(negedge clk);
    cmdChg = 1'b0;
  endtask

  // headend deletes up to one flow each way
  task automatic t_hdel(input logic [FLOW_ID_WIDTH-1:0] up, dn,
      input int rr, gone);
    int n0, r0;
    logic [FLOW_COUNT-1:0] f0;
    n0 = sentCount;
    r0 = nRereg;
    f0 = flowActive;
    @(negedge clk);
    cmdDel = 1'b1;
    cmdUpId = up;
    cmdDnId = dn;
    @(negedge clk);
    cmdDel = 1'b0;
    wait_sent(n0 + 1);
    `CHK(sentMsg, MSG_DEL_RSP)
    `CHK(sentUp, up)
    `CHK(sentDn, dn)
    cyc(4);
    `CHK($countones(f0 & ~flowActive), gone)
    `CHK(flowActive & ~f0, 8'h00)
    `CHK(nRereg, r0 + rr)
  endtask

  // modem asks to drop one up and one down flow, headend slow to listen
  task automatic t_ldel();
    int n0;
    logic [FLOW_COUNT-1:0] f0;
    n0 = sentCount;
    f0 = flowActive;
    rdyDelay = 8'h03;
    `CHK(localDelReady, 1'b1)
    localDelValid = 1'b1;
    localDelUpId = 16'h0033;
    localDelDnId = 16'h0044;
    @(negedge clk);
    localDelValid = 1'b0;
    wait_sent(n0 + 1);
    `CHK(sentMsg, MSG_DEL_REQ)
    `CHK({sentUp, sentDn}, 32'h00330044)
    `CHK(localDelReady, 1'b0)
    cyc(6);
    `CHK(localDelReady, 1'b1)
    `CHK($countones(f0 & ~flowActive), 2)
    rdyDelay = 8'h00;
  endtask

  task automatic t_change(input logic up, dn, pres, input sdc_init_type tech);
    int n0, ri, rg, fl, k;
    logic reinit;
    reinit = !pres || tech == INIT_REINIT_MAC;
    n0 = sentCount;
    ri = nReinit;
    rg = nRange;
    fl = nFlush;
    rdyDelay = 8'h04;
    chg(up, dn, pres, tech);
    wait_sent(n0 + 1);
    `CHK(sentMsg, MSG_DEP_RSP)
    wait_jump(1'b1, k);
    `CHK({jumpUp, jumpDn}, {up, dn})
    `CHK(useOldGrants, 1'b0)
    wait_jump(1'b0, k);
    if (!reinit) `CHK(useNewGrants, 1'b1)
    cyc(12);
    `CHK(sentCount, n0 + (reinit ? 1 : 2))
    if (!reinit) `CHK(sentMsg, MSG_ARR_RSP)
    `CHK(nReinit, ri + (reinit ? 1 : 0))
    if (tech != INIT_RANGE_OR_DIRECT) `CHK(nRange, rg + ((!reinit &&
        (tech == INIT_BROADCAST_RANGE || tech == INIT_UNICAST_RANGE)) ?
        1 : 0))
    `CHK(nFlush, fl + 1)
  endtask

  // depart response never granted; a repeat command restarts the limit
  task automatic t_t13();
    int n0, k;
    n0 = sentCount;
    rdyDelay = 8'hff;
    chg(1'b1, 1'b1, 1'b1, INIT_DIRECT);
    cyc(100);
    `CHK(useOldGrants, 1'b1)
    `CHK(jumpReq, 1'b0)
    `CHK(localDelReady, 1'b0)
    chg(1'b1, 1'b1, 1'b1, INIT_DIRECT);
    wait_jump(1'b1, k);
    `CHK(k > 150 && k <= T13_SIM, 1'b1)
    rdyDelay = 8'h00;
    wait_sent(n0 + 1);
    `CHK(sentMsg, MSG_ARR_RSP)
  endtask

  // a hang is cut short well beyond the expected few hundred cycles
  initial begin
    #80000;
    failures++;
    close_out();
  end

  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    `CHK(txMsg, MSG_NONE)
    `CHK(useOldGrants, 1'b1)
    `CHK(localDelReady, 1'b0)
    registered = 1'b1;
    for (int i = 1; i <= 4; i++) begin
      @(negedge clk);
      addValid = 1'b1;
      addId = 16'(i * 17);
      addPrimary = (i == 1);
      addProvisioned = (i == 2);
    end
    @(negedge clk);
    addValid = 1'b0;
    cyc(2);
    `CHK(flowActive, 8'h0f)
    `CHK(provKept, 8'h02)
    t_ldel();
    t_hdel(16'h0022, 16'h0000, 0, 1);
    `CHK(provKept, 8'h00)
    t_hdel(16'h0011, 16'h0000, 1, 1);
    for (int k = 0; k < 6; k++) begin
      t_change(k != 1, k != 0, k < 5, sdc_init_type'(3'(k == 5 ? 4 : k)));
    end
    t_t13();
    close_out();
  end
endmodule
